// file: rtl/vpdr_pkg.sv
package vpdr_pkg;
  // Page codes served by this block.
  localparam logic [7:0] VPDR_PAGE_POWER = 8'h8D;
  localparam logic [7:0] VPDR_PAGE_LU = 8'h90;
  localparam logic [7:0] VPDR_PAGE_PORT = 8'h91;
  // Header and field values.
  localparam logic [7:0] VPDR_BYTE0 = 8'h00;
  localparam logic [7:0] VPDR_POWER_LEN = 8'h04;
  localparam logic [7:0] VPDR_PROTO_LEN = 8'h18;
  localparam logic [7:0] VPDR_POWER_SEL = 8'h00;
  localparam logic [7:0] VPDR_UNITS_MW = 8'h04;
  localparam logic [7:0] VPDR_REL_PORT_A = 8'h01;
  localparam logic [7:0] VPDR_REL_PORT_B = 8'h02;
  localparam logic [7:0] VPDR_PROTO_SAS = 8'h06;
  localparam logic [7:0] VPDR_DESC_LEN = 8'h04;
  localparam logic [7:0] VPDR_RETRY_CTRL = 8'h00;
  localparam logic [7:0] VPDR_PWR_CUT = 8'h01;
  localparam logic [7:0] VPDR_PERSIST = 8'h00;
  localparam logic [7:0] VPDR_PHY_A = 8'h00;
  localparam logic [7:0] VPDR_PHY_B = 8'h01;
  // Byte positions within a page and within a descriptor.
  localparam logic [4:0] VPDR_POWER_LAST = 5'h07;
  localparam logic [4:0] VPDR_PROTO_LAST = 5'h1B;
  localparam logic [4:0] VPDR_DESC0_BASE = 5'h04;
  localparam logic [4:0] VPDR_DESC1_BASE = 5'h10;
  localparam logic [4:0] VPDR_OFF_RELPORT = 5'h01;
  localparam logic [4:0] VPDR_OFF_PROTO = 5'h02;
  localparam logic [4:0] VPDR_OFF_FLAGS = 5'h03;
  localparam logic [4:0] VPDR_OFF_DLEN = 5'h07;
  localparam logic [4:0] VPDR_OFF_RETRY = 5'h08;
  localparam logic [4:0] VPDR_OFF_PHY = 5'h09;
  localparam logic [4:0] VPDR_OFF_PERSIST = 5'h0A;
  localparam int VPDR_FIFO_DEPTH = 32;
  localparam logic [1:0] VPDR_RSYNC_RESET = 2'h0;

  typedef enum logic {VPDR_IDLE, VPDR_STREAM} vpdr_state_t;
endpackage : vpdr_pkg

// file: rtl/vpdr_page_responder.sv
// Notes on behaviour
// - Byte 0 of every page is zero: qualifier zero, direct-access device type.
// - Byte 1 echoes the requested page code.
// - Power page length field in bytes 2-3 reads 4.
// - Power page byte 4 holds selector value zero.
// - Power page byte 5 holds units code 4, meaning milliwatts, upper bits zero.
// - Power page bytes 6-7 carry the sixteen-bit maximum power value.
// - Logical unit page length reads 24, two twelve-byte descriptors at 4-15, 16-27.
// - Descriptor bytes 0-1 carry relative port 1 for primary, 2 for secondary.
// - Descriptor byte 2 holds protocol code 6; bytes 6-7 hold length 0004h.
// - Logical unit descriptor byte 8 retry control support reads zero.
// - Port page length reads 24 with two twelve-byte port descriptors.
// - Port descriptor byte 3 bit 0 set, power cutoff supported.
// - Port descriptor bytes 8-11 hold PHY block; PHY number 0 or 1.
// - PHY block persistent connection capability reads zero.
`timescale 1ns/1ps

module vpdr_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } vpdr_fifo_t;

  vpdr_fifo_t st_reg;
  vpdr_fifo_t st_next;
  logic push;
  logic pop;

  assign in_ready_o = (st_reg.count != DEPTH[AW:0]);
  assign out_valid_o = (st_reg.count != '0);
  assign out_data_o = st_reg.mem[st_reg.rptr];
  assign push = ce_i && in_valid_i && in_ready_o;
  assign pop = ce_i && out_valid_o && out_ready_i;

  always_comb
  begin
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wptr] = in_data_i;
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (pop)
    begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
    st_next.count = st_reg.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
endmodule : vpdr_fifo

module vpdr_page_responder #(
  parameter int FIFO_DEPTH = vpdr_pkg::VPDR_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic [7:0] page_code_i,
  input wire logic [15:0] max_power_i,
  output logic unsupported_o,
  output logic busy_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [7:0] out_data_o,
  output logic out_last_o
);
  typedef struct packed {
    vpdr_pkg::vpdr_state_t state;
    logic [7:0] page;
    logic [15:0] power;
    logic [4:0] idx;
    logic unsupported;
  } vpdr_core_t;

  logic [1:0] rsync_reg;
  logic rst_n;
  vpdr_core_t st_reg;
  vpdr_core_t st_next;
  logic req_fire;
  logic supported;
  logic push;
  logic push_last;
  logic fifo_ready;
  logic [7:0] push_byte;

  // Reset is released through two flops so every core and FIFO flop leaves reset on the same edge.
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rsync_reg <= vpdr_pkg::VPDR_RSYNC_RESET;
    end
    else
    begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end
  assign rst_n = rsync_reg[1];

  // Builds one byte of the page image from the page code, byte index and power value.
  function automatic logic [7:0] page_byte(input logic [7:0] pg, input logic [4:0] idx, input logic [15:0] pwr);
    logic second;
    logic [4:0] off;
    second = (idx >= vpdr_pkg::VPDR_DESC1_BASE);
    off = second ? idx - vpdr_pkg::VPDR_DESC1_BASE : idx - vpdr_pkg::VPDR_DESC0_BASE;
    page_byte = 8'h00;
    case (idx)
      5'h00: page_byte = vpdr_pkg::VPDR_BYTE0;
      5'h01: page_byte = pg;
      5'h02: page_byte = 8'h00;
      5'h03: page_byte = (pg == vpdr_pkg::VPDR_PAGE_POWER) ? vpdr_pkg::VPDR_POWER_LEN : vpdr_pkg::VPDR_PROTO_LEN;
      default:
      begin
        if (pg == vpdr_pkg::VPDR_PAGE_POWER)
        begin
          case (idx)
            5'h04: page_byte = vpdr_pkg::VPDR_POWER_SEL;
            5'h05: page_byte = vpdr_pkg::VPDR_UNITS_MW;
            5'h06: page_byte = pwr[15:8];
            5'h07: page_byte = pwr[7:0];
            default: page_byte = 8'h00;
          endcase
        end
        else
        begin
          case (off)
            vpdr_pkg::VPDR_OFF_RELPORT: page_byte = second ? vpdr_pkg::VPDR_REL_PORT_B : vpdr_pkg::VPDR_REL_PORT_A;
            vpdr_pkg::VPDR_OFF_PROTO: page_byte = vpdr_pkg::VPDR_PROTO_SAS;
            vpdr_pkg::VPDR_OFF_FLAGS: page_byte = (pg == vpdr_pkg::VPDR_PAGE_PORT) ? vpdr_pkg::VPDR_PWR_CUT : 8'h00;
            vpdr_pkg::VPDR_OFF_DLEN: page_byte = vpdr_pkg::VPDR_DESC_LEN;
            vpdr_pkg::VPDR_OFF_RETRY: page_byte = vpdr_pkg::VPDR_RETRY_CTRL;
            vpdr_pkg::VPDR_OFF_PHY:
            begin
              if (pg == vpdr_pkg::VPDR_PAGE_PORT)
              begin
                page_byte = second ? vpdr_pkg::VPDR_PHY_B : vpdr_pkg::VPDR_PHY_A;
              end
            end
            vpdr_pkg::VPDR_OFF_PERSIST: page_byte = vpdr_pkg::VPDR_PERSIST;
            default: page_byte = 8'h00;
          endcase
        end
      end
    endcase
  endfunction : page_byte

  assign supported = (page_code_i == vpdr_pkg::VPDR_PAGE_POWER) || (page_code_i == vpdr_pkg::VPDR_PAGE_LU) ||
    (page_code_i == vpdr_pkg::VPDR_PAGE_PORT);
  assign req_ready_o = (st_reg.state == vpdr_pkg::VPDR_IDLE);
  assign req_fire = ce_i && req_valid_i && req_ready_o;
  assign push = ce_i && (st_reg.state == vpdr_pkg::VPDR_STREAM) && fifo_ready;
  assign push_byte = page_byte(st_reg.page, st_reg.idx, st_reg.power);
  assign push_last = (st_reg.page == vpdr_pkg::VPDR_PAGE_POWER) ? (st_reg.idx == vpdr_pkg::VPDR_POWER_LAST) :
    (st_reg.idx == vpdr_pkg::VPDR_PROTO_LAST);
  assign busy_o = (st_reg.state == vpdr_pkg::VPDR_STREAM);
  assign unsupported_o = st_reg.unsupported;

  always_comb
  begin
    st_next = st_reg;
    if (ce_i)
    begin
      st_next.unsupported = 1'b0;
    end
    case (st_reg.state)
      vpdr_pkg::VPDR_IDLE:
      begin
        if (req_fire)
        begin
          // The power value is captured here so the two bytes always form one sample.
          st_next.page = page_code_i;
          st_next.power = max_power_i;
          st_next.idx = 5'h00;
          st_next.unsupported = !supported;
          st_next.state = vpdr_pkg::VPDR_IDLE;
          if (supported)
          begin
            st_next.state = vpdr_pkg::VPDR_STREAM;
          end
        end
      end
      vpdr_pkg::VPDR_STREAM:
      begin
        if (push)
        begin
          st_next.idx = st_reg.idx + 5'h01;
          if (push_last)
          begin
            st_next.state = vpdr_pkg::VPDR_IDLE;
          end
        end
      end
      default: st_next.state = vpdr_pkg::VPDR_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // The FIFO lets a stalled consumer back-pressure the generator instead of dropping bytes.
  vpdr_fifo #(
    .WIDTH(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i({push_last, push_byte}),
    .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i),
    .out_data_o({out_last_o, out_data_o})
  );

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    req_fire && supported;
  endsequence
  sequence s_first_byte;
    busy_o && (st_reg.idx == 5'h00) && (st_reg.power == $past(max_power_i));
  endsequence

  property p_start;
    s_accept |=> s_first_byte;
  endproperty
  a_start: assert property (p_start) else $error("stream did not start at byte zero");

  property p_byte0;
    push && (st_reg.idx == 5'h00) |-> push_byte == 8'h00;
  endproperty
  a_byte0: assert property (p_byte0) else $error("byte zero not zero");

  property p_page_echo;
    push && (st_reg.idx == 5'h01) |-> push_byte == st_reg.page;
  endproperty
  a_page_echo: assert property (p_page_echo) else $error("page code not echoed");

  property p_len;
    push && (st_reg.idx == 5'h03) |->
      push_byte == ((st_reg.page == vpdr_pkg::VPDR_PAGE_POWER) ? 8'h04 : 8'h18);
  endproperty
  a_len: assert property (p_len) else $error("page length wrong");

  property p_power_tail;
    push && (st_reg.page == vpdr_pkg::VPDR_PAGE_POWER) && (st_reg.idx == 5'h05) |->
      push_byte == 8'h04 ##0 (st_reg.power[15:8] == page_byte(st_reg.page, 5'h06, st_reg.power));
  endproperty
  a_power_tail: assert property (p_power_tail) else $error("power units or value wrong");

  property p_relport;
    push && (st_reg.page != vpdr_pkg::VPDR_PAGE_POWER) && (st_reg.idx == 5'h11) |-> push_byte == 8'h02;
  endproperty
  a_relport: assert property (p_relport) else $error("secondary relative port wrong");

  property p_proto;
    push && (st_reg.page != vpdr_pkg::VPDR_PAGE_POWER) && (st_reg.idx == 5'h06) |-> push_byte == 8'h06;
  endproperty
  a_proto: assert property (p_proto) else $error("protocol code wrong");

  property p_pwr_cut;
    push && (st_reg.page == vpdr_pkg::VPDR_PAGE_PORT) && (st_reg.idx == 5'h13) |-> push_byte == 8'h01;
  endproperty
  a_pwr_cut: assert property (p_pwr_cut) else $error("power cutoff flag missing");

  property p_phy;
    push && (st_reg.page == vpdr_pkg::VPDR_PAGE_PORT) && (st_reg.idx == 5'h19) |-> push_byte == 8'h01;
  endproperty
  a_phy: assert property (p_phy) else $error("secondary PHY number wrong");

  property p_end;
    push && push_last |=> !busy_o && req_ready_o;
  endproperty
  a_end: assert property (p_end) else $error("stream did not end after last byte");
endmodule : vpdr_page_responder

// file: tb/vpdr_sink_model.sv
`timescale 1ns/1ps

module vpdr_sink_model (
  input wire logic clk_i,
  input wire logic [1:0] mode_i,
  output logic ready_o
);
  logic [1:0] phase_reg = 2'h0;

  // Mode 0 stalls, mode 1 takes every byte, mode 2 takes one byte in three.
  // A slow initiator is what lets the responder's buffer back up.
  always @(posedge clk_i)
  begin
    phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
    ready_o <= (mode_i == 2'h1) || (mode_i == 2'h2 && phase_reg == 2'h0);
  end
endmodule : vpdr_sink_model

// file: tb/vpdr_page_responder_tb.sv
`timescale 1ns/1ps

module vpdr_page_responder_tb;
  logic clk_i;
  logic rstn_i;
  logic ce_i;
  logic req_valid_i;
  logic req_ready_o;
  logic [7:0] page_code_i;
  logic [15:0] max_power_i;
  logic unsupported_o;
  logic busy_o;
  logic out_valid_o;
  logic out_ready_i;
  logic [7:0] out_data_o;
  logic out_last_o;
  logic [1:0] mode;
  logic [8:0] q[$];
  int err_count;
  int compares;

  vpdr_page_responder dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .page_code_i(page_code_i), .max_power_i(max_power_i), .unsupported_o(unsupported_o), .busy_o(busy_o),
    .out_valid_o(out_valid_o), .out_ready_i(out_ready_i), .out_data_o(out_data_o), .out_last_o(out_last_o)
  );

  vpdr_sink_model sink (.clk_i(clk_i), .mode_i(mode), .ready_o(out_ready_i));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Bytes are recorded at the same edge that pops them from the buffer.
  always @(posedge clk_i)
  begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
      q.push_back({out_last_o, out_data_o});
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask : chk1

  task automatic finish_test;
    $display("err_count=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  function automatic logic [7:0] exp_byte(input logic [7:0] pg, input int i, input logic [15:0] pw);
    int d;
    d = (i >= 16) ? i - 16 : i - 4;
    if (i < 4)
      return (i == 1) ? pg : (i == 3) ? ((pg == 8'h8D) ? 8'h04 : 8'h18) : 8'h00;
    // Power page: selector, milliwatt units, value high byte first.
    if (pg == 8'h8D)
      return (i == 5) ? 8'h04 : (i == 6) ? pw[15:8] : (i == 7) ? pw[7:0] : 8'h00;
    // Descriptor: relative port, protocol, cutoff flag, length, phy number.
    case (d)
      1: return (i >= 16) ? 8'h02 : 8'h01;
      2: return 8'h06;
      3: return (pg == 8'h91) ? 8'h01 : 8'h00;
      7: return 8'h04;
      9: return (pg == 8'h91 && i >= 16) ? 8'h01 : 8'h00;
      default: return 8'h00;
    endcase
  endfunction : exp_byte

  task automatic request(input logic [7:0] pg, input logic [15:0] pw);
    int n;
    n = 0;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    page_code_i <= pg;
    max_power_i <= pw;
    #1;
    while (req_ready_o !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // A request that is never taken counts as a mismatch.
    if (n >= 200)
      err_count++;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
  endtask : request

  task automatic read_page(input logic [7:0] pg, input logic [15:0] pw);
    int len;
    int n;
    logic [8:0] b;
    len = (pg == 8'h8D) ? 8 : 28;
    n = 0;
    while (q.size() < len && n < 400)
    begin
      @(posedge clk_i);
      n++;
    end
    for (int i = 0; i < len; i++)
    begin
      b = (q.size() > 0) ? q.pop_front() : 9'h1_FF;
      chk8(b[7:0], exp_byte(pg, i, pw));
      chk1(b[8], i == len - 1);
    end
  endtask : read_page

  initial
  begin
    #800000;
    err_count++;
    finish_test();
  end

  initial
  begin
    logic [7:0] pages[3];
    err_count = 0;
    compares = 0;
    pages = '{8'h8D, 8'h90, 8'h91};
    rstn_i = 1'b0;
    ce_i = 1'b1;
    req_valid_i = 1'b0;
    page_code_i = 8'h00;
    max_power_i = 16'h0000;
    mode = 2'h1;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk1(req_ready_o, 1'b1);
    chk1(busy_o, 1'b0);
    chk1(out_valid_o, 1'b0);
    foreach (pages[k])
    begin
      request(pages[k], 16'h1234);
      read_page(pages[k], 16'h1234);
    end
    mode <= 2'h2;
    request(8'h8D, 16'hFFFF);
    read_page(8'h8D, 16'hFFFF);
    request(8'h8D, 16'h8001);
    read_page(8'h8D, 16'h8001);
    // A low clock enable holds the generator before its first byte, with nothing lost.
    request(8'h8D, 16'h5AC3);
    ce_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk8(8'(q.size()), 8'h00);
    chk1(busy_o, 1'b1);
    ce_i <= 1'b1;
    read_page(8'h8D, 16'h5AC3);
    // An unsupported code gets one pulse and no bytes.
    request(8'h8A, 16'h0000);
    #1;
    chk1(unsupported_o, 1'b1);
    @(posedge clk_i);
    #1;
    chk1(unsupported_o, 1'b0);
    repeat (10) @(posedge clk_i);
    chk8(8'(q.size()), 8'h00);
    // Second page queued behind a stalled first one fills the buffer and stalls the generator.
    mode <= 2'h0;
    request(8'h90, 16'h0000);
    #1;
    chk1(busy_o, 1'b1);
    chk1(req_ready_o, 1'b0);
    request(8'h91, 16'h0000);
    repeat (40) @(posedge clk_i);
    chk8(8'(q.size()), 8'h00);
    chk1(out_valid_o, 1'b1);
    mode <= 2'h2;
    read_page(8'h90, 16'h0000);
    read_page(8'h91, 16'h0000);
    repeat (5) @(posedge clk_i);
    chk1(out_valid_o, 1'b0);
    finish_test();
  end
endmodule : vpdr_page_responder_tb
